// file: hw/bkm_burst_plan.v
// burst geometry: keystream start offset, payload length and subfield layout
// assumes its inputs are held stable for the whole burst
`timescale 1ns/100ps
`default_nettype none
`include "bkm_consts.vh"

module bkm_burst_plan (
  // burst setup
  input wire i_format,
  input wire [2:0] i_config,
  input wire [1:0] i_slot,
  input wire [15:0] i_keystream_segment_length,
  input wire [15:0] i_q_4ab,
  input wire [2:0] i_codec_ratio,
  input wire [5:0] i_num_subfields,
  // derived geometry
  output reg [15:0] o_offset,
  output reg [15:0] o_payload_bits,
  output reg [15:0] o_sub_size,
  output reg [15:0] o_sub_data,
  output reg [15:0] o_seg_len
);

  reg [15:0] q;
  reg [31:0] prod;

  always @* begin
    // longer segments than the concatenation limit are clamped
    if (i_keystream_segment_length > `BKM_KSS_MAX) begin // [R9]
      o_seg_len = `BKM_KSS_MAX;
    end else begin
      o_seg_len = i_keystream_segment_length; // [R3]
    end
    case (i_config)
      `BKM_CFG_4A: o_offset = `BKM_OFS_4A; // [R6] [R10]
      `BKM_CFG_4B: o_offset = `BKM_OFS_4B; // [R7] [R10]
      default: o_offset = `BKM_OFS_STD; // [R5] [R10]
    endcase
    if (i_config == `BKM_CFG_4A || i_config == `BKM_CFG_4B) begin
      q = i_q_4ab;
    end else begin
      q = o_seg_len - `BKM_OFS_STD; // [R4]
    end
    case (i_slot)
      `BKM_SLOT_HALF: o_sub_size = `BKM_SIZE_HALF; // [R1]
      `BKM_SLOT_FULL: o_sub_size = `BKM_SIZE_FULL;
      `BKM_SLOT_DOUBLE: o_sub_size = `BKM_SIZE_DOUBLE;
      default: o_sub_size = `BKM_SIZE_LONG;
    endcase
    o_sub_data = o_sub_size - `BKM_SUB_CRC; // [R2]
    if (i_format == `BKM_FMT_ENCODED) begin
      prod = q * {13'h0000, i_codec_ratio}; // [R5]
    end else begin
      prod = o_sub_size * {10'h000, i_num_subfields}; // [R1]
    end
    o_payload_bits = prod[15:0];
  end

endmodule // bkm_burst_plan

`default_nettype wire

// file: hw/bkm_consts.vh
// constants for the b-field keystream mixer
// assumes a single 50 MHz burst clock and a bit-serial keystream source
//
// Contract
// R1: constant-size subfield equals single 2-level b-field size of the slot type
// R2: constant-size mode xors data bits only; crc passes, its keystream bit dropped
// R3: keystream segment indexed from zero to segment length minus one
// R4: q equals segment length minus 40 except configurations 4a and 4b
// R5: encoded format, other configurations: payload uses keystream from bit 40
// R6: encoded format, configuration 4a: payload uses keystream from bit 80
// R7: encoded format, configuration 4b: payload uses keystream from bit 120
// R8: keystream bits after the last used one are discarded to segment end
// R9: concatenated keystream segments are at most 1680 bits long
// R10: subfield x bit i uses keystream bit 80x+i+offset; the mixer uses sub_size*x+i+offset, so 80x only in half slots
// R11: controller holds format, configuration, slot type and ratio stable per burst
`ifndef BKM_CONSTS_VH
`define BKM_CONSTS_VH

// ----------------------------------------
// formats
// ----------------------------------------
`define BKM_FMT_ENCODED 1'b0
`define BKM_FMT_CONST 1'b1

// ----------------------------------------
// modulation configurations
// ----------------------------------------
`define BKM_CFG_1A 3'h0
`define BKM_CFG_1B 3'h1
`define BKM_CFG_2 3'h2
`define BKM_CFG_3 3'h3
`define BKM_CFG_4A 3'h4
`define BKM_CFG_4B 3'h5
`define BKM_CFG_5 3'h6
`define BKM_CFG_6 3'h7

// ----------------------------------------
// slot types
// ----------------------------------------
`define BKM_SLOT_HALF 2'h0
`define BKM_SLOT_FULL 2'h1
`define BKM_SLOT_DOUBLE 2'h2
`define BKM_SLOT_LONG 2'h3

// ----------------------------------------
// single-subfield 2-level b-field sizes
// ----------------------------------------
`define BKM_SIZE_HALF 16'h0050
`define BKM_SIZE_FULL 16'h0140
`define BKM_SIZE_DOUBLE 16'h0320
`define BKM_SIZE_LONG 16'h0280

// ----------------------------------------
// keystream offsets and limits
// ----------------------------------------
`define BKM_OFS_STD 16'h0028
`define BKM_OFS_4A 16'h0050
`define BKM_OFS_4B 16'h0078
`define BKM_KSS_MAX 16'h0690
`define BKM_SUB_CRC 16'h0010

`endif

// file: hw/bkm_mixer.v
// b-field keystream mixer: xors one keystream segment onto a serial payload
// assumes bit-serial keystream, payload and output streams with valid/ready,
// one burst per i_start pulse, and setup inputs held for the burst
`timescale 1ns/100ps
`default_nettype none
`include "bkm_consts.vh"

module bkm_mixer (
  // clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  // burst setup
  input wire i_start,
  input wire i_format,
  input wire [2:0] i_config,
  input wire [1:0] i_slot,
  input wire [15:0] i_keystream_segment_length,
  input wire [15:0] i_q_4ab,
  input wire [2:0] i_codec_ratio,
  input wire [5:0] i_num_subfields,
  // keystream in
  input wire i_ks_valid,
  input wire i_ks_bit,
  output wire o_ks_ready,
  // payload in
  input wire i_pl_valid,
  input wire i_pl_bit,
  output wire o_pl_ready,
  // mixed payload out
  output reg o_out_valid,
  output reg o_out_bit,
  input wire i_out_ready,
  // status
  output wire o_busy,
  output reg o_done
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SKIP = 4'h2;
  localparam [3:0] ST_MIX = 4'h4;
  localparam [3:0] ST_DRAIN = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [15:0] ks_idx_q;
  reg [15:0] ks_idx_d;
  reg [15:0] pl_cnt_q;
  reg [15:0] pl_cnt_d;
  reg [15:0] sub_pos_q;
  reg [15:0] sub_pos_d;
  reg out_valid_d;
  reg out_bit_d;
  reg done_d;

  wire [15:0] offset;
  wire [15:0] payload_bits;
  wire [15:0] sub_size;
  wire [15:0] sub_data;
  wire [15:0] seg_len;

  // ----------------------------------------
  // burst geometry
  // ----------------------------------------
  // setup is read combinationally throughout the burst [R11]
  bkm_burst_plan u_plan (
    .i_format(i_format),
    .i_config(i_config),
    .i_slot(i_slot),
    .i_keystream_segment_length(i_keystream_segment_length),
    .i_q_4ab(i_q_4ab),
    .i_codec_ratio(i_codec_ratio),
    .i_num_subfields(i_num_subfields),
    .o_offset(offset),
    .o_payload_bits(payload_bits),
    .o_sub_size(sub_size),
    .o_sub_data(sub_data),
    .o_seg_len(seg_len)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // true when idx sits on the final position of a run of len bits
  function is_last;
    input [15:0] idx;
    input [15:0] len;
    begin
      is_last = (idx == len - 16'h0001);
    end
  endfunction

  // state after the offset: with no payload the segment goes straight to its tail
  function [3:0] work_state;
    input [15:0] n_bits;
    begin
      if (n_bits == 16'h0000) begin
        work_state = ST_DRAIN;
      end else begin
        work_state = ST_MIX;
      end
    end
  endfunction

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  wire out_space = ~o_out_valid | i_out_ready;
  // a payload bit moves only with its keystream bit and room at the output
  wire mix_go = (state_q == ST_MIX) & i_ks_valid & i_pl_valid & out_space;
  wire last_ks = is_last(ks_idx_q, seg_len);
  wire last_pl = is_last(pl_cnt_q, payload_bits);
  wire is_data = (i_format == `BKM_FMT_ENCODED) | (sub_pos_q < sub_data); // [R2]

  assign o_ks_ready = (state_q == ST_SKIP) | (state_q == ST_DRAIN) | mix_go;
  assign o_pl_ready = mix_go;
  assign o_busy = (state_q != ST_IDLE);

  function [15:0] inc16;
    input [15:0] v;
    begin
      inc16 = v + 16'h0001;
    end
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    ks_idx_d = ks_idx_q;
    pl_cnt_d = pl_cnt_q;
    sub_pos_d = sub_pos_q;
    out_valid_d = o_out_valid & ~i_out_ready;
    out_bit_d = o_out_bit;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (i_start) begin
          ks_idx_d = 16'h0000; // [R3]
          pl_cnt_d = 16'h0000;
          sub_pos_d = 16'h0000;
          if (seg_len == 16'h0000) begin
            done_d = 1'b1;
          end else if (offset == 16'h0000) begin
            state_d = work_state(payload_bits);
          end else begin
            state_d = ST_SKIP;
          end
        end
      end
      ST_SKIP: begin
        // leading keystream bits ahead of the payload offset are dropped
        if (i_ks_valid) begin // [R5] [R6] [R7]
          ks_idx_d = inc16(ks_idx_q);
          if (last_ks) begin
            state_d = ST_IDLE;
            done_d = 1'b1;
          end else if (is_last(ks_idx_q, offset)) begin
            state_d = work_state(payload_bits);
          end
        end
      end
      ST_MIX: begin
        if (mix_go) begin
          out_valid_d = 1'b1;
          // crc positions pass untouched but still use up a keystream bit
          out_bit_d = is_data ? (i_pl_bit ^ i_ks_bit) : i_pl_bit; // [R2] [R5] [R10]
          ks_idx_d = inc16(ks_idx_q);
          pl_cnt_d = inc16(pl_cnt_q);
          if (is_last(sub_pos_q, sub_size)) begin // [R1] [R10]
            sub_pos_d = 16'h0000;
          end else begin
            sub_pos_d = inc16(sub_pos_q);
          end
          if (last_ks) begin
            // segment exhausted: payload beyond it is not mixed
            state_d = ST_IDLE;
            done_d = 1'b1;
          end else if (last_pl) begin
            state_d = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        // unused tail of the segment is consumed and dropped
        if (i_ks_valid) begin // [R8]
          ks_idx_d = inc16(ks_idx_q);
          if (last_ks) begin
            state_d = ST_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      ks_idx_q <= 16'h0000;
      pl_cnt_q <= 16'h0000;
      sub_pos_q <= 16'h0000;
      o_out_valid <= 1'b0;
      o_out_bit <= 1'b0;
      o_done <= 1'b0;
    end else begin
      state_q <= state_d;
      ks_idx_q <= ks_idx_d;
      pl_cnt_q <= pl_cnt_d;
      sub_pos_q <= sub_pos_d;
      o_out_valid <= out_valid_d;
      o_out_bit <= out_bit_d;
      o_done <= done_d;
    end
  end

endmodule // bkm_mixer

`default_nettype wire

// file: sim/bkm_ks_src.sv
// keystream generator model feeding the mixer, one bit per take
// assumes the bench clock; i_hold stalls the stream for a cycle
`timescale 1ns/100ps
`default_nettype none
module bkm_ks_src (
  // control
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic i_busy,
  input wire logic i_hold,
  // stream
  input wire logic i_ready,
  output logic o_valid,
  output logic o_bit,
  output int o_count
);
  initial begin
    o_valid = 1'b0;
    o_bit = 1'b0;
  end
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) o_count <= 0;
    else if (i_start && !i_busy) o_count <= 0;
    else if (o_valid && i_ready) o_count <= o_count + 1;
  end
  // a stalled bit flips so a stale value can never be mistaken for data
  always @(negedge i_core_clk) begin
    o_valid <= !i_hold;
    o_bit <= i_hold ? !o_bit : (o_count[0] ^ o_count[3]);
  end
endmodule // bkm_ks_src
`default_nettype wire

// file: sim/bkm_mixer_monitor.sv
// protocol checker for the keystream mixer
// assumes it is bound to bkm_mixer and sees its ports only
`timescale 1ns/100ps
`default_nettype none
module bkm_mixer_monitor (
  // watched ports
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [15:0] i_keystream_segment_length,
  input wire logic i_ks_valid,
  input wire logic o_ks_ready,
  input wire logic i_pl_valid,
  input wire logic o_pl_ready,
  input wire logic o_out_valid,
  input wire logic o_out_bit,
  input wire logic i_out_ready,
  input wire logic o_busy,
  input wire logic o_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  AST_OUT_LAT: assert property (i_ks_valid && o_ks_ready && i_pl_valid && o_pl_ready |=> o_out_valid)
    else $error("mixed bit missing after a take");
  AST_STAND: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_bit))
    else $error("mixed bit changed while stalled");
  AST_SKIP: assert property ($rose(o_busy) |-> !o_pl_ready [*8])
    else $error("payload taken inside the offset");
  AST_START: assert property (!o_busy && !o_done && i_start && i_keystream_segment_length != 16'h0000 |=> o_busy)
    else $error("start not honoured");
  AST_IDLE: assert property (!o_busy |-> !o_ks_ready && !o_pl_ready)
    else $error("stream taken while idle");
  AST_DONE: assert property (o_done |-> !o_busy ##1 !o_done)
    else $error("done not a single pulse");
  AST_PAIR: assert property (o_pl_ready |-> o_ks_ready && i_ks_valid)
    else $error("payload taken without keystream");
  AST_END: assert property ($fell(o_busy) |-> o_done)
    else $error("burst ended without done");
endmodule // bkm_mixer_monitor
bind bkm_mixer bkm_mixer_monitor i_mon (
  .i_core_clk(i_core_clk),
  .i_rstn(i_rstn),
  .i_start(i_start),
  .i_keystream_segment_length(i_keystream_segment_length),
  .i_ks_valid(i_ks_valid),
  .o_ks_ready(o_ks_ready),
  .i_pl_valid(i_pl_valid),
  .o_pl_ready(o_pl_ready),
  .o_out_valid(o_out_valid),
  .o_out_bit(o_out_bit),
  .i_out_ready(i_out_ready),
  .o_busy(o_busy),
  .o_done(o_done)
);
`default_nettype wire

// file: sim/bkm_mixer_test.sv
// self-checking bench for bkm_mixer with a keystream source model
// assumes half slots except full slots in t_const_full, payload always offered, sink and source stalling
`timescale 1ns/100ps
`default_nettype none
module bkm_mixer_test;
  logic i_core_clk = 1'b0, i_rstn = 1'b0, i_start = 1'b0, i_format = 1'b0;
  logic [2:0] i_config = 3'h0, i_codec_ratio = 3'h0;
  logic [1:0] i_slot = 2'h0;
  logic [15:0] i_keystream_segment_length = 16'h0000, i_q_4ab = 16'h0000;
  logic [5:0] i_num_subfields = 6'h00;
  logic i_ks_valid, i_ks_bit, o_ks_ready, o_pl_ready, o_out_valid, o_out_bit, o_busy, o_done;
  logic i_pl_valid = 1'b1, i_pl_bit = 1'b0, i_out_ready = 1'b1, hold = 1'b0, cst = 1'b0;
  int errors = 0, checks = 0, m = 0, pk = 0, cyc = 0, ofs = 0, ssz = 80, ks_cnt;
  bkm_mixer i_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start),
    .i_format(i_format), .i_config(i_config), .i_slot(i_slot),
    .i_keystream_segment_length(i_keystream_segment_length), .i_q_4ab(i_q_4ab),
    .i_codec_ratio(i_codec_ratio), .i_num_subfields(i_num_subfields),
    .i_ks_valid(i_ks_valid), .i_ks_bit(i_ks_bit), .o_ks_ready(o_ks_ready),
    .i_pl_valid(i_pl_valid), .i_pl_bit(i_pl_bit), .o_pl_ready(o_pl_ready),
    .o_out_valid(o_out_valid), .o_out_bit(o_out_bit), .i_out_ready(i_out_ready),
    .o_busy(o_busy), .o_done(o_done));
  bkm_ks_src i_src (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start),
    .i_busy(o_busy), .i_hold(hold), .i_ready(o_ks_ready), .o_valid(i_ks_valid),
    .o_bit(i_ks_bit), .o_count(ks_cnt));
  always #10 i_core_clk = ~i_core_clk;
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic ex(int k);
    int j;
    logic kb;
    j = ofs + k;
    kb = j[0] ^ j[3];
    if (cst && k % ssz >= ssz - 16) kb = 1'b0;
    return k[1] ^ k[4] ^ kb;
  endfunction
  always @(posedge i_core_clk) begin
    if (i_pl_valid && o_pl_ready) pk <= pk + 1;
    if (o_out_valid && i_out_ready) begin
      check("out_bit", o_out_bit, ex(m));
      m++;
    end
  end
  // sink stalls every fifth cycle, source every seventh
  always @(negedge i_core_clk) begin
    cyc++;
    i_pl_bit <= pk[1] ^ pk[4];
    i_out_ready <= (cyc % 5 != 0);
    hold <= (cyc % 7 == 3);
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic run(input logic f, input logic [2:0] c, r, input logic [15:0] len, q4,
      input logic [5:0] n, input int o, np);
    int t;
    @(negedge i_core_clk);
    {i_format, i_config, i_codec_ratio, i_q_4ab, i_num_subfields} = {f, c, r, q4, n};
    i_keystream_segment_length = len;
    {ofs, cst, m, pk} = {o, f, 32'h0, 32'h0};
    i_start = 1'b1;
    @(negedge i_core_clk) i_start = 1'b0;
    repeat (3) @(negedge i_core_clk);
    // a second start inside the burst must be ignored
    i_start = 1'b1;
    @(negedge i_core_clk) i_start = 1'b0;
    t = 0;
    while (o_done !== 1'b1 && t < 5000) begin
      @(negedge i_core_clk);
      t++;
    end
    check("done", o_done, 1'b1);
    check("busy", o_busy, 1'b0);
    t = 0;
    while (o_out_valid !== 1'b0 && t < 9) begin
      @(negedge i_core_clk);
      t++;
    end
    check("out_valid", o_out_valid, 1'b0);
    check("payload_count", m, np);
    check("ks_count", ks_cnt, (len > 16'h0690) ? 16'h0690 : len);
  endtask
  task t_enc_1a; run(0, 3'h0, 3'h1, 16'h002A, 16'h0000, 6'h00, 40, 2); endtask
  task t_enc_6; run(0, 3'h7, 3'h3, 16'h002D, 16'h0000, 6'h00, 40, 5); endtask
  task t_enc_4a; run(0, 3'h4, 3'h2, 16'h0064, 16'h0003, 6'h00, 80, 6); endtask
  task t_enc_4b; run(0, 3'h5, 3'h3, 16'h0082, 16'h0002, 6'h00, 120, 6); endtask
  task t_const; run(1, 3'h0, 3'h1, 16'h00C8, 16'h0000, 6'h02, 40, 160); endtask
  task t_clamp; run(0, 3'h1, 3'h1, 16'h07D0, 16'h0000, 6'h00, 40, 1640); endtask
  // a single full slot subfield with the 4a offset and a dropped tail
  task t_const_full;
    i_slot = 2'h1;
    ssz = 320;
    run(1, 3'h4, 3'h1, 16'h01A0, 16'h0000, 6'h01, 80, 320);
    i_slot = 2'h0;
    ssz = 80;
  endtask
  task t_empty; run(0, 3'h6, 3'h1, 16'h0000, 16'h0000, 6'h00, 40, 0); endtask
  initial begin
    repeat (4) @(negedge i_core_clk);
    i_rstn = 1'b1;
    t_enc_1a;
    t_enc_6;
    t_enc_4a;
    t_enc_4b;
    t_const;
    t_clamp;
    t_const_full;
    t_empty;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    end_of_test;
  end
endmodule // bkm_mixer_test
`default_nettype wire
